//--- bench/pmt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_chk (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   tbl_start,
    input wire pmt_pkg::pmt_tbl_form_t tbl_form,
    input wire logic                   tbl_busy,
    input wire logic                   tbl_done,
    input wire logic                   dm_wr_en,
    input wire logic [8:0]             dm_wr_addr,
    input wire logic                   tdh_wr_en,
    input wire logic [7:0]             table_data_high,
    input wire logic                   prog_mode,
    input wire logic                   debug_variant,
    input wire logic [10:0]            pc,
    input wire logic                   gpio_da_i,
    input wire logic                   prog_serial_clock_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic take;
    assign take = tbl_start && !tbl_busy && !prog_mode;
    a_busy_next: assert property (take |=> tbl_busy) else $error("busy late");
    a_busy_len: assert property ($rose(tbl_busy) |-> tbl_busy [*8] ##1 !tbl_busy) else $error("busy len");
    a_done_late: assert property (take |-> ##9 tbl_done) else $error("done late");
    a_done_pair: assert property (tbl_done |-> dm_wr_en && $past(tbl_busy)) else $error("done alone");
    a_std_sector: assert property (tbl_done && $past(tbl_form, 9) == pmt_pkg::TBL_FORM_STD
        |-> !dm_wr_addr[8]) else $error("std sector");
    a_pc_zero: assert property (!$past(rst_n) |-> pc == 11'h000) else $error("pc reset");
    a_tdh_source: assert property ($changed(table_data_high) |-> tbl_done || $past(tdh_wr_en))
        else $error("tdh change");
    a_clk_input: assert property (prog_mode && $past(prog_mode) |-> !prog_serial_clock_oe) else $error("ck oe");
    a_dbg_cut: assert property (debug_variant && $past(debug_variant) |-> !gpio_da_i) else $error("dbg pin");
endmodule
`default_nettype wire

//--- bench/pmt_prog_tool.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_prog_tool (
    input  wire logic clk_sys,
    input  wire logic dq,
    output logic      ck,
    output logic      da
);
    initial {ck, da} = 2'h0;
    // clock idles low between frames; data shows the inverse once released
    task automatic write_word(input logic [10:0] a, input logic [15:0] d);
        logic [27:0] f;
        f = {1'b1, a, d};
        for (int i = 27; i >= 0; i--) begin
            da <= f[i];
            repeat (3) @(posedge clk_sys);
            ck <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ck <= 1'b0;
        end
        da <= ~f[0];
        repeat (4) @(posedge clk_sys);
    endtask
    // read frame: line released after the address, word taken two and a half system clocks after each fall
    task automatic read_word(input logic [10:0] a, output logic [15:0] d);
        logic [11:0] f;
        f = {1'b0, a};
        for (int i = 11; i >= 0; i--) begin
            da <= f[i];
            repeat (3) @(posedge clk_sys);
            ck <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ck <= 1'b0;
        end
        da <= ~f[0];
        for (int i = 15; i >= 0; i--) begin
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys) d[i] = dq;
            @(posedge clk_sys) ck <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ck <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

//--- bench/pmt_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_top_tb_top;
    logic clk_sys, rst_n, pc_step, pc_load, tbl_start, tdh_wr_en, prog_mode, debug_variant, gpio_da_i;
    logic gpio_da_o, gpio_ck_o, dbg_da_o, ck, da, da_o, da_oe, instr_valid, tbl_busy, tbl_done, dm_wr_en;
    logic [10:0]            pc_load_addr, pc;
    logic [15:0]            instr_word, w[2], rd;
    logic                   dbg_da_i, tbl_form_err;
    logic [7:0]             tbl_ptr_low, tbl_ptr_high, tdh_wr_data, table_data_high, dm_wr_data;
    logic [8:0]             tbl_dest, dm_wr_addr;
    pmt_pkg::pmt_tbl_form_t tbl_form;
    logic [31:0]            rs, err_total, checks;
    logic [24:0]            got, q[$];
    pmt_top pmt_top_inst (.*, .gpio_da_oe(1'b0), .gpio_ck_oe(1'b1), .dbg_da_oe(1'b0),
        .gpio_ck_i(), .dbg_ck_i(), .prog_serial_data_i(da_oe ? da_o : da),
        .prog_serial_data_o(da_o), .prog_serial_data_oe(da_oe), .prog_serial_clock_i(ck),
        .prog_serial_clock_o(), .prog_serial_clock_oe());
    pmt_prog_tool pmt_prog_tool_inst (.clk_sys(clk_sys), .dq(da_oe ? da_o : da), .ck(ck), .da(da));
    assign got = {dm_wr_addr, dm_wr_data, table_data_high};
    always #20 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic finish_test();
        if (err_total == 0 && checks != 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string nm, input logic [24:0] e, g);
        checks++;
        if (!ok) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a second start while busy must be ignored, so it is slipped in here
    task automatic wt(input logic sel);
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            tbl_start <= !sel && n == 1;
            @(negedge clk_sys);
            if ((sel ? instr_valid : tbl_done) === 1'b1) return;
        end
        err_total++;
        finish_test();
    endtask
    always @(negedge clk_sys) begin
        if (dm_wr_en === 1'b1) begin
            chk(q.size() != 0 && got === q[0], "table", q[0], got);
            if (q.size() != 0) void'(q.pop_front());
        end
    end
    initial begin
        {clk_sys, rst_n, pc_step, pc_load, tbl_start, tdh_wr_en, prog_mode, debug_variant} = '0;
        {gpio_da_o, gpio_ck_o, dbg_da_o, pc_load_addr, tbl_ptr_low, tbl_ptr_high, tdh_wr_data, tbl_dest} = '0;
        tbl_form = pmt_pkg::TBL_FORM_STD;
        {rs, err_total, checks} = {32'hab4a, 64'h0};
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        prog_mode <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            rs = xs(rs);
            w[i] = rs[15:0];
            pmt_prog_tool_inst.write_word(i ? 11'h706 : 11'h306, w[i]);
        end
        pmt_prog_tool_inst.read_word(11'h306, rd);
        chk(rd === w[0], "read", 25'(w[0]), 25'(rd));
        prog_mode <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            @(posedge clk_sys);
            rs = xs(rs);
            tbl_form <= pmt_pkg::pmt_tbl_form_t'(f[1:0]);
            {tbl_start, tbl_ptr_low} <= {1'b1, 8'h06};
            tbl_ptr_high <= f[0] ? rs[15:8] : {rs[15:11], 3'h3};
            tbl_dest <= rs[24:16];
            q.push_back({f[1] & rs[24], rs[23:16], w[f[0]][7:0], w[f[0]][15:8]});
            @(posedge clk_sys);
            tbl_start <= 1'b0;
            wt(1'b0);
            chk(tbl_form_err === (!f[1] && rs[24]), "ferr", 25'(!f[1] && rs[24]), 25'(tbl_form_err));
        end
        @(posedge clk_sys);
        {tdh_wr_en, tdh_wr_data, debug_variant, gpio_da_o, gpio_ck_o} <= {1'b1, rs[7:0], 3'h7};
        {pc_load, pc_load_addr} <= {1'b1, 11'h706};
        @(posedge clk_sys);
        {tdh_wr_en, pc_load} <= 2'h0;
        @(negedge clk_sys);
        chk(table_data_high === rs[7:0], "tdh", 25'(rs[7:0]), 25'(table_data_high));
        chk(gpio_da_i === 1'b0, "gpio", 25'h0, 25'(gpio_da_i));
        chk(dbg_da_i === da, "dbg", 25'(da), 25'(dbg_da_i));
        repeat (4) @(negedge clk_sys);
        wt(1'b1);
        chk(instr_word === w[1], "fetch", 25'(w[1]), 25'(instr_word));
        @(posedge clk_sys) pc_step <= 1'b1;
        @(posedge clk_sys) pc_step <= 1'b0;
        @(negedge clk_sys);
        chk(pc === 11'h707, "pc", 25'h707, 25'(pc));
        finish_test();
    end
endmodule
bind pmt_top pmt_chk pmt_chk_inst (.*);
`default_nettype wire

//--- rtl/pmt_icp.sv
`timescale 1ns/1ps
`default_nettype none

module pmt_icp (
    input  wire logic                              clk_sys,
    input  wire logic                              rst_n,
    input  wire logic                              enable,
    input  wire logic                              ck_i,
    input  wire logic                              da_i,
    output logic                                   da_o,
    output logic                                   da_oe,
    output logic                                   wr_req,
    output logic                                   rd_req,
    output logic [pmt_pkg::PM_ADDR_W-1:0]          addr,
    output logic [pmt_pkg::PM_DATA_W-1:0]          wr_data,
    input  wire logic [pmt_pkg::PM_DATA_W-1:0]     rd_data
);
    // ****************************************************************
    // serial frame engine
    // ****************************************************************
    typedef enum logic [2:0] {IC_CMD, IC_ADDR, IC_DIN, IC_FETCH, IC_LOAD, IC_DOUT} pmt_icp_st_t;

    pmt_icp_st_t                   st_q, st_d;
    logic [4:0]                    cnt_q, cnt_d;
    logic                          cmd_q, cmd_d;
    logic                          ck_prev_q;
    logic [pmt_pkg::PM_ADDR_W-1:0] addr_q, addr_d;
    logic [pmt_pkg::PM_DATA_W-1:0] sh_q, sh_d;
    logic                          oe_q, oe_d;
    logic                          o_q, o_d;
    logic                          wr_q, wr_d;
    logic                          rd_q, rd_d;
    logic                          rise;
    logic                          fall;

    assign rise = ck_i & ~ck_prev_q;
    assign fall = ~ck_i & ck_prev_q;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        cmd_d  = cmd_q;
        addr_d = addr_q;
        sh_d   = sh_q;
        oe_d   = oe_q;
        o_d    = o_q;
        wr_d   = 1'b0;
        rd_d   = 1'b0;
        if (!enable) begin
            st_d  = IC_CMD;
            oe_d  = 1'b0;
            cnt_d = 5'h00;
        end else begin
            unique case (st_q)
                IC_CMD: if (rise) begin
                    cmd_d = da_i;
                    cnt_d = 5'h00;
                    st_d  = IC_ADDR;
                end
                IC_ADDR: if (rise) begin
                    addr_d = {addr_q[pmt_pkg::PM_ADDR_W-2:0], da_i};
                    cnt_d  = cnt_q + 5'h01;
                    if (cnt_q == pmt_pkg::ICP_ADDR_LAST) begin
                        cnt_d = 5'h00;
                        st_d  = (cmd_q == pmt_pkg::ICP_CMD_WRITE) ? IC_DIN : IC_FETCH;
                        rd_d  = (cmd_q != pmt_pkg::ICP_CMD_WRITE);
                    end
                end
                IC_DIN: if (rise) begin
                    sh_d  = {sh_q[pmt_pkg::PM_DATA_W-2:0], da_i};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == pmt_pkg::ICP_DATA_LAST) begin
                        wr_d = 1'b1;
                        st_d = IC_CMD;
                    end
                end
                IC_FETCH: st_d = IC_LOAD;
                IC_LOAD: begin
                    sh_d = rd_data;
                    st_d = IC_DOUT;
                end
                IC_DOUT: if (fall) begin
                    // device drives the shared line only between falling edges
                    oe_d  = (cnt_q <= pmt_pkg::ICP_DATA_LAST);
                    o_d   = sh_q[pmt_pkg::PM_DATA_W-1];
                    sh_d  = {sh_q[pmt_pkg::PM_DATA_W-2:0], 1'b0};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q > pmt_pkg::ICP_DATA_LAST) begin
                        st_d = IC_CMD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= IC_CMD;
            cnt_q     <= 5'h00;
            cmd_q     <= 1'b0;
            ck_prev_q <= 1'b0;
            addr_q    <= '0;
            sh_q      <= '0;
            oe_q      <= 1'b0;
            o_q       <= 1'b0;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            cmd_q     <= cmd_d;
            ck_prev_q <= ck_i;
            addr_q    <= addr_d;
            sh_q      <= sh_d;
            oe_q      <= oe_d;
            o_q       <= o_d;
            wr_q      <= wr_d;
            rd_q      <= rd_d;
        end
    end

    assign da_o    = o_q;
    assign da_oe   = oe_q;
    assign wr_req  = wr_q;
    assign rd_req  = rd_q;
    assign addr    = addr_q;
    assign wr_data = sh_q;
endmodule

`default_nettype wire

//--- rtl/pmt_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pmt_mem_if;
    logic                              rd_en;
    logic [pmt_pkg::PM_ADDR_W-1:0]     rd_addr;
    logic [pmt_pkg::PM_DATA_W-1:0]     rd_data;
    logic                              wr_en;
    logic [pmt_pkg::PM_ADDR_W-1:0]     wr_addr;
    logic [pmt_pkg::PM_DATA_W-1:0]     wr_data;

    modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
    modport user (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
endinterface

`default_nettype wire

//--- rtl/pmt_pkg.sv
package pmt_pkg;

    // ****************************************************************
    // memory geometry
    // ****************************************************************
    localparam int unsigned PM_WORDS      = 2048;
    localparam int unsigned PM_ADDR_W     = 11;
    localparam int unsigned PM_DATA_W     = 16;
    localparam int unsigned DM_ADDR_W     = 9;

    localparam logic [PM_ADDR_W-1:0] RESET_VECTOR   = 11'h000;
    localparam logic [PM_ADDR_W-1:0] LAST_PAGE_BASE = 11'h700;
    localparam logic [7:0]           TDH_USED_MASK  = 8'hff;
    localparam logic [7:0]           TDH_RESET      = 8'h00;
    localparam logic [2:0]           PTR_HIGH_MASK  = 3'h7;

    // ****************************************************************
    // timing: one instruction cycle is the four phases of the system clock
    // ****************************************************************
    localparam int unsigned PHASES_PER_ICYCLE = 4;
    localparam int unsigned TBL_ICYCLES       = 2;
    localparam int unsigned TBL_CLKS          = PHASES_PER_ICYCLE * TBL_ICYCLES;
    localparam logic [3:0]  TBL_LAST_CNT      = 4'(TBL_CLKS - 1);

    // ****************************************************************
    // serial programming frame: command bit, address, data word
    // ****************************************************************
    localparam logic       ICP_CMD_WRITE = 1'b1;
    localparam logic [4:0] ICP_ADDR_LAST = 5'(PM_ADDR_W - 1);
    localparam logic [4:0] ICP_DATA_LAST = 5'(PM_DATA_W - 1);

    typedef enum logic [1:0] {
        TBL_FORM_STD,
        TBL_FORM_STD_LAST,
        TBL_FORM_EXT,
        TBL_FORM_EXT_LAST
    } pmt_tbl_form_t;

endpackage

//--- rtl/pmt_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none

module pmt_prog_mem (
    input  wire logic   clk_sys,
    pmt_mem_if.mem      bus
);
    // ****************************************************************
    // word array with registered read
    // ****************************************************************
    logic [pmt_pkg::PM_DATA_W-1:0] store [pmt_pkg::PM_WORDS];
    logic [pmt_pkg::PM_DATA_W-1:0] rd_q;

    // no reset on the array: flash contents are not cleared by a device reset
    always_ff @(posedge clk_sys) begin
        if (bus.wr_en) begin
            store[bus.wr_addr] <= bus.wr_data;
        end
        if (bus.rd_en) begin
            rd_q <= store[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_q;
endmodule

`default_nettype wire

//--- rtl/pmt_top.sv
`timescale 1ns/1ps
`default_nettype none

module pmt_top (
    input  wire logic                              clk_sys,
    input  wire logic                              rst_n,
    input  wire logic                              pc_step,
    input  wire logic                              pc_load,
    input  wire logic [pmt_pkg::PM_ADDR_W-1:0]     pc_load_addr,
    output logic [pmt_pkg::PM_ADDR_W-1:0]          pc,
    output logic [pmt_pkg::PM_DATA_W-1:0]          instr_word,
    output logic                                   instr_valid,
    input  wire logic                              tbl_start,
    input  wire pmt_pkg::pmt_tbl_form_t            tbl_form,
    input  wire logic [7:0]                        tbl_ptr_low,
    input  wire logic [7:0]                        tbl_ptr_high,
    input  wire logic [pmt_pkg::DM_ADDR_W-1:0]     tbl_dest,
    output logic                                   tbl_busy,
    output logic                                   tbl_done,
    output logic                                   tbl_form_err,
    output logic                                   dm_wr_en,
    output logic [pmt_pkg::DM_ADDR_W-1:0]          dm_wr_addr,
    output logic [7:0]                             dm_wr_data,
    input  wire logic                              tdh_wr_en,
    input  wire logic [7:0]                        tdh_wr_data,
    output logic [7:0]                             table_data_high,
    input  wire logic                              prog_mode,
    input  wire logic                              debug_variant,
    input  wire logic                              gpio_da_o,
    input  wire logic                              gpio_da_oe,
    input  wire logic                              gpio_ck_o,
    input  wire logic                              gpio_ck_oe,
    output logic                                   gpio_da_i,
    output logic                                   gpio_ck_i,
    input  wire logic                              dbg_da_o,
    input  wire logic                              dbg_da_oe,
    output logic                                   dbg_da_i,
    output logic                                   dbg_ck_i,
    input  wire logic                              prog_serial_data_i,
    output logic                                   prog_serial_data_o,
    output logic                                   prog_serial_data_oe,
    input  wire logic                              prog_serial_clock_i,
    output logic                                   prog_serial_clock_o,
    output logic                                   prog_serial_clock_oe
);
    // ****************************************************************
    // program memory and its single read port
    // ****************************************************************
    pmt_mem_if mem_bus ();

    pmt_prog_mem u_mem (
        .clk_sys (clk_sys),
        .bus     (mem_bus)
    );

    // ****************************************************************
    // serial programming engine on the shared data and clock pins
    // ****************************************************************
    logic                          icp_da_o;
    logic                          icp_da_oe;
    logic                          icp_wr;
    logic                          icp_rd;
    logic [pmt_pkg::PM_ADDR_W-1:0] icp_addr;
    logic [pmt_pkg::PM_DATA_W-1:0] icp_wdata;

    pmt_icp u_icp (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .enable  (prog_mode),
        .ck_i    (prog_serial_clock_i),
        .da_i    (prog_serial_data_i),
        .da_o    (icp_da_o),
        .da_oe   (icp_da_oe),
        .wr_req  (icp_wr),
        .rd_req  (icp_rd),
        .addr    (icp_addr),
        .wr_data (icp_wdata),
        .rd_data (mem_bus.rd_data)
    );

    // ****************************************************************
    // table read sequencer
    // ****************************************************************
    typedef enum logic [1:0] {TB_IDLE, TB_RUN} pmt_tbl_st_t;

    pmt_tbl_st_t                   tst_q, tst_d;
    logic [3:0]                    tcnt_q, tcnt_d;
    logic [pmt_pkg::PM_ADDR_W-1:0] taddr_q, taddr_d;
    logic [pmt_pkg::DM_ADDR_W-1:0] tdest_q, tdest_d;
    logic [pmt_pkg::PM_DATA_W-1:0] tword_q, tword_d;
    logic                          terr_q, terr_d;
    logic                          tdone_q, tdone_d;
    logic                          dmw_q, dmw_d;
    logic [pmt_pkg::DM_ADDR_W-1:0] dma_q, dma_d;
    logic [7:0]                    dmd_q, dmd_d;
    logic [7:0]                    tdh_q, tdh_d;
    logic                          last_page;
    logic                          ext_form;
    logic [pmt_pkg::PM_ADDR_W-1:0] tbl_addr;
    logic                          tbl_rd_now;
    logic                          busy_q, busy_d;

    assign last_page = (tbl_form == pmt_pkg::TBL_FORM_STD_LAST) || (tbl_form == pmt_pkg::TBL_FORM_EXT_LAST);
    assign ext_form  = (tbl_form == pmt_pkg::TBL_FORM_EXT) || (tbl_form == pmt_pkg::TBL_FORM_EXT_LAST);

    // last page keeps the page bits of the base and takes only the low pointer
    assign tbl_addr = last_page ? {pmt_pkg::LAST_PAGE_BASE[pmt_pkg::PM_ADDR_W-1:8], tbl_ptr_low}
                                : {tbl_ptr_high[2:0] & pmt_pkg::PTR_HIGH_MASK, tbl_ptr_low};

    // read is issued on the first clock of the run; the data are caught on the next
    assign tbl_rd_now = (tst_q == TB_RUN) && (tcnt_q == 4'h0);

    always_comb begin
        tst_d   = tst_q;
        tcnt_d  = tcnt_q;
        taddr_d = taddr_q;
        tdest_d = tdest_q;
        tword_d = tword_q;
        terr_d  = terr_q;
        tdone_d = 1'b0;
        dmw_d   = 1'b0;
        dma_d   = dma_q;
        dmd_d   = dmd_q;
        tdh_d   = tdh_q;
        if (tdh_wr_en) begin
            tdh_d = tdh_wr_data;
        end
        unique case (tst_q)
            TB_IDLE: if (tbl_start && !prog_mode) begin
                tst_d   = TB_RUN;
                tcnt_d  = 4'h0;
                taddr_d = tbl_addr;
                // standard forms can only reach sector 0, so the sector bit is cut
                tdest_d = ext_form ? tbl_dest : {1'b0, tbl_dest[7:0]};
                terr_d  = !ext_form && tbl_dest[8];
            end
            TB_RUN: begin
                tcnt_d = tcnt_q + 4'h1;
                if (tcnt_q == 4'h1) begin
                    tword_d = mem_bus.rd_data;
                end
                if (tcnt_q == pmt_pkg::TBL_LAST_CNT) begin
                    tst_d   = TB_IDLE;
                    tdone_d = 1'b1;
                    dmw_d   = 1'b1;
                    dma_d   = tdest_q;
                    dmd_d   = tword_q[7:0];
                    // the table load lands after any software write in the same clock
                    tdh_d   = tword_q[15:8] & pmt_pkg::TDH_USED_MASK;
                end
            end
            default: tst_d = TB_IDLE;
        endcase
        // busy is kept in its own flop so the output does not come through a compare
        busy_d = (tst_d == TB_RUN);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tst_q   <= TB_IDLE;
            tcnt_q  <= 4'h0;
            taddr_q <= '0;
            tdest_q <= '0;
            tword_q <= '0;
            terr_q  <= 1'b0;
            tdone_q <= 1'b0;
            dmw_q   <= 1'b0;
            dma_q   <= '0;
            dmd_q   <= 8'h00;
            tdh_q   <= pmt_pkg::TDH_RESET;
            busy_q  <= 1'b0;
        end else begin
            tst_q   <= tst_d;
            tcnt_q  <= tcnt_d;
            taddr_q <= taddr_d;
            tdest_q <= tdest_d;
            tword_q <= tword_d;
            terr_q  <= terr_d;
            tdone_q <= tdone_d;
            dmw_q   <= dmw_d;
            dma_q   <= dma_d;
            dmd_q   <= dmd_d;
            tdh_q   <= tdh_d;
            busy_q  <= busy_d;
        end
    end

    // ****************************************************************
    // program counter and instruction fetch
    // ****************************************************************
    logic [pmt_pkg::PM_ADDR_W-1:0] pc_q, pc_d;
    logic [pmt_pkg::PM_DATA_W-1:0] iw_q, iw_d;
    logic                          iv_q, iv_d;
    logic                          fetch_q, fetch_d;

    // programmer wins the port, then a table read, then fetch
    always_comb begin
        mem_bus.wr_en   = icp_wr && prog_mode;
        mem_bus.wr_addr = icp_addr;
        mem_bus.wr_data = icp_wdata;
        mem_bus.rd_en   = 1'b1;
        if (icp_rd && prog_mode) begin
            mem_bus.rd_addr = icp_addr;
        end else if (tbl_rd_now) begin
            mem_bus.rd_addr = taddr_q;
        end else begin
            mem_bus.rd_addr = pc_q;
        end
    end

    always_comb begin
        pc_d    = pc_q;
        if (pc_load) begin
            pc_d = pc_load_addr;
        end else if (pc_step) begin
            pc_d = pc_q + 11'h001;
        end
        fetch_d = !prog_mode && !icp_rd && !tbl_rd_now;
        iv_d    = fetch_q;
        iw_d    = fetch_q ? mem_bus.rd_data : iw_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_q    <= pmt_pkg::RESET_VECTOR;
            iw_q    <= '0;
            iv_q    <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            pc_q    <= pc_d;
            iw_q    <= iw_d;
            iv_q    <= iv_d;
            fetch_q <= fetch_d;
        end
    end

    // ****************************************************************
    // shared pins: port function, programming and debug link
    // ****************************************************************
    logic pda_o_q, pda_o_d;
    logic pda_oe_q, pda_oe_d;
    logic pck_o_q, pck_o_d;
    logic pck_oe_q, pck_oe_d;
    logic gda_q, gda_d;
    logic gck_q, gck_d;
    logic dda_q, dda_d;
    logic dck_q, dck_d;

    always_comb begin
        // the pin clock is never driven while programming or debugging
        pck_o_d  = gpio_ck_o;
        pck_oe_d = gpio_ck_oe && !prog_mode && !debug_variant;
        if (prog_mode) begin
            pda_o_d  = icp_da_o;
            pda_oe_d = icp_da_oe;
        end else if (debug_variant) begin
            pda_o_d  = dbg_da_o;
            pda_oe_d = dbg_da_oe;
        end else begin
            pda_o_d  = gpio_da_o;
            pda_oe_d = gpio_da_oe;
        end
        // port function sees a quiet low level while the pins serve another party
        gda_d = prog_serial_data_i && !prog_mode && !debug_variant;
        gck_d = prog_serial_clock_i && !prog_mode && !debug_variant;
        dda_d = prog_serial_data_i && debug_variant;
        dck_d = prog_serial_clock_i && debug_variant;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pda_o_q  <= 1'b0;
            pda_oe_q <= 1'b0;
            pck_o_q  <= 1'b0;
            pck_oe_q <= 1'b0;
            gda_q    <= 1'b0;
            gck_q    <= 1'b0;
            dda_q    <= 1'b0;
            dck_q    <= 1'b0;
        end else begin
            pda_o_q  <= pda_o_d;
            pda_oe_q <= pda_oe_d;
            pck_o_q  <= pck_o_d;
            pck_oe_q <= pck_oe_d;
            gda_q    <= gda_d;
            gck_q    <= gck_d;
            dda_q    <= dda_d;
            dck_q    <= dck_d;
        end
    end

    // ****************************************************************
    // outputs, all from flip-flops
    // ****************************************************************
    assign pc                   = pc_q;
    assign instr_word           = iw_q;
    assign instr_valid          = iv_q;
    assign tbl_busy             = busy_q;
    assign tbl_done             = tdone_q;
    assign tbl_form_err         = terr_q;
    assign dm_wr_en             = dmw_q;
    assign dm_wr_addr           = dma_q;
    assign dm_wr_data           = dmd_q;
    assign table_data_high      = tdh_q;
    assign gpio_da_i            = gda_q;
    assign gpio_ck_i            = gck_q;
    assign dbg_da_i             = dda_q;
    assign dbg_ck_i             = dck_q;
    assign prog_serial_data_o   = pda_o_q;
    assign prog_serial_data_oe  = pda_oe_q;
    assign prog_serial_clock_o  = pck_o_q;
    assign prog_serial_clock_oe = pck_oe_q;
endmodule

`default_nettype wire
